// file: include/pzc_params.svh
// constants for the phase/zone configuration register bank
// assumes an 8-bit register port and a 100 MHz clock
`ifndef PZC_PARAMS_SVH
`define PZC_PARAMS_SVH
`define PZC_A_DOWNEN 8'h31
`define PZC_A_PSI 8'h32
`define PZC_A_PHASE 8'h33
`define PZC_A_ZONEEN 8'h34
`define PZC_A_ZSTRAP 8'h35
`define PZC_A_ZCFG 8'h36
`define PZC_A_LOADLINE 8'h39
`define PZC_A_TH1CFG 8'h3A
`define PZC_A_TH1STR 8'h3B
`define PZC_A_TH2CFG 8'h3C
`define PZC_A_TH2STR 8'h3D
`define PZC_A_TH3CFG 8'h3E
`define PZC_A_TH3STR 8'h3F
`define PZC_A_TH4CFG 8'h40
`define PZC_A_TH4STR 8'h41
`define PZC_A_HYST 8'h44
`define PZC_A_DELAY 8'h45
`define PZC_A_LATCHA 8'h46
`define PZC_A_LATCHB 8'h47
`define PZC_A_OUTPUT_VOLTAGE_MONITOR 8'h48
`define PZC_A_POWER_STAGE_TEMP_MONITOR 8'h49
`define PZC_RST_DOWNEN 1'h1
`define PZC_RST_ZONEEN 5'h1F
`define PZC_RST_LOADLINE 2'h3
`define PZC_RST_DELAY 8'h14
`define PZC_TH_OFF 8'hFF
`define PZC_B_FREQ 5
`define PZC_B_SOFT 3
`define PZC_B_ILIM 2
`define PZC_B_ZONE 1
`define PZC_B_TH 0
`define PZC_DELAY_STEP_NS 30000
`define PZC_CLK_NS 10
`define PZC_DELAY_STEP_CYC ((`PZC_DELAY_STEP_NS + `PZC_CLK_NS - 1) / `PZC_CLK_NS)
`endif

// file: include/pzc_pkg.sv
// types for the phase/zone configuration register bank
package pzc_pkg;
  typedef enum logic [2:0] {
    PZC_IDLE = 3'b001,
    PZC_WAIT = 3'b010,
    PZC_DROP = 3'b100
  } pzc_shed_t;
endpackage

// file: hdl/pzc_regs.sv
// register bank and phase shedding for a multiphase controller
// assumes a synchronous byte register port and straps stable around reset release
`timescale 1ns/100ps
`default_nettype none
`include "pzc_params.svh"

module pzc_regs (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire logic [1:0] powerSavingInput,
  input wire logic [5:0] strapZone,
  input wire logic [31:0] strapThreshold,
  input wire logic [3:0] strapThresholdOver2V,
  input wire logic [4:0] strapFreq,
  input wire logic [7:0] cfgFreq,
  input wire logic [7:0] outputCurrentReadback,
  input wire logic [7:0] outputVoltageMonitor,
  input wire logic [7:0] powerStageTempMonitor,
  output logic [7:0] phaseEnable,
  output logic downStepPhaseChangeEn,
  output logic [4:0] lowPowerZoneEnables,
  output logic [2:0] zoneLevelFirst,
  output logic [1:0] zoneLevelSecond,
  output logic [1:0] loadLineFraction,
  output logic [4:0] freqCode,
  output logic [4:0] controlSource
);
  import pzc_pkg::*;

  logic downEn_r;
  logic [4:0] zoneEn_r;
  logic [5:0] zoneCfg_r;
  logic [5:0] zoneStrap_r;
  logic [1:0] loadLine_r;
  logic [7:0] thCfg_r [4];
  logic [7:0] thStrap_r [4];
  logic [7:0] hyst_r;
  logic [7:0] delay_r;
  logic [7:0] latchA_r;
  logic [7:0] latchB_r;
  logic [7:0] select_r;
  logic strapDone_r;
  logic [7:0] phaseEn_r;
  logic [7:0] rdata_r;
  pzc_shed_t shedState_r;
  logic [23:0] waitCnt_r;
  logic [3:0] phaseCnt_r;
  logic [7:0] activeTh [4];
  logic [2:0] wantIdx;
  logic [3:0] wantPhases;
  logic [3:0] lowerBelow;
  logic [23:0] delayCycles;
  logic [1:0] dropIdx;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      downEn_r <= `PZC_RST_DOWNEN;
      zoneEn_r <= `PZC_RST_ZONEEN;
      zoneCfg_r <= 6'h00;
      loadLine_r <= `PZC_RST_LOADLINE;
      hyst_r <= 8'h00;
      delay_r <= `PZC_RST_DELAY;
      latchA_r <= 8'h00;
      latchB_r <= 8'h00;
      for (int i = 0; i < 4; i++) begin
        thCfg_r[i] <= `PZC_TH_OFF;
      end
    end else if (regWrite) begin
      case (regAddr)
        `PZC_A_DOWNEN: downEn_r <= regWdata[0];
        `PZC_A_ZONEEN: zoneEn_r <= regWdata[4:0];
        `PZC_A_ZCFG: zoneCfg_r <= regWdata[5:0];
        `PZC_A_LOADLINE: loadLine_r <= regWdata[1:0];
        `PZC_A_TH1CFG: thCfg_r[0] <= regWdata;
        `PZC_A_TH2CFG: thCfg_r[1] <= regWdata;
        `PZC_A_TH3CFG: thCfg_r[2] <= regWdata;
        `PZC_A_TH4CFG: thCfg_r[3] <= regWdata;
        `PZC_A_HYST: hyst_r <= regWdata;
        `PZC_A_DELAY: delay_r <= regWdata;
        `PZC_A_LATCHA: latchA_r <= regWdata;
        `PZC_A_LATCHB: latchB_r <= regWdata;
        default: begin
        end
      endcase
    end
  end

  // the working selection only moves once both latches agree
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      select_r <= 8'h00;
    end else if (latchA_r == latchB_r) begin
      select_r <= latchA_r;
    end
  end

  // straps caught on the first clock after reset release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strapDone_r <= 1'b0;
      zoneStrap_r <= 6'h00;
      for (int i = 0; i < 4; i++) begin
        thStrap_r[i] <= `PZC_TH_OFF;
      end
    end else if (!strapDone_r) begin
      strapDone_r <= 1'b1;
      zoneStrap_r <= strapZone;
      for (int i = 0; i < 4; i++) begin
        thStrap_r[i] <= strapThresholdOver2V[i] ? `PZC_TH_OFF : strapThreshold[8*i +: 8];
      end
    end
  end

  // reserved zone codes hold level 0 rather than an undefined level
  always_comb begin
    logic [5:0] z;
    z = select_r[`PZC_B_ZONE] ? zoneCfg_r : zoneStrap_r;
    zoneLevelFirst = (z[5:3] <= 3'h4) ? z[5:3] : 3'h0;
    case (z[2:0])
      3'h0: zoneLevelSecond = 2'h0;
      3'h1: zoneLevelSecond = 2'h1;
      3'h2: zoneLevelSecond = 2'h2;
      3'h3: zoneLevelSecond = 2'h3;
      3'h4: zoneLevelSecond = 2'h3;
      default: zoneLevelSecond = 2'h0;
    endcase
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      activeTh[i] = select_r[`PZC_B_TH] ? thCfg_r[i] : thStrap_r[i];
    end
    // threshold i sits between i+1 and i+2 phases groups, threshold 3 between 4 and 8; lowest phase count wins
    wantIdx = 3'h4;
    lowerBelow = 4'h0;
    for (int i = 3; i >= 0; i--) begin
      if (activeTh[i] != `PZC_TH_OFF && outputCurrentReadback < activeTh[i]) begin
        wantIdx = 3'(i);
      end
      if (activeTh[i] != `PZC_TH_OFF &&
          {1'b0, outputCurrentReadback} + {1'b0, hyst_r} < {1'b0, activeTh[i]}) begin
        lowerBelow[i] = 1'b1;
      end
    end
    wantPhases = (wantIdx == 3'h4) ? 4'h8 : 4'(wantIdx + 3'h1);
    delayCycles = 24'(delay_r) * 24'(`PZC_DELAY_STEP_CYC);
    // only four thresholds exist, so five phases and up all shed against the top one
    if (phaseCnt_r > 4'h5) begin
      dropIdx = 2'h3;
    end else if (phaseCnt_r > 4'h1) begin
      dropIdx = 2'(phaseCnt_r - 4'h2);
    end else begin
      dropIdx = 2'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shedState_r <= PZC_IDLE;
      waitCnt_r <= 24'h0;
      phaseCnt_r <= 4'h8;
    end else begin
      case (shedState_r)
        PZC_IDLE: begin
          waitCnt_r <= 24'h0;
          if (wantPhases > phaseCnt_r) begin
            phaseCnt_r <= wantPhases;
          end else if (wantPhases < phaseCnt_r && lowerBelow[dropIdx]) begin
            shedState_r <= PZC_WAIT;
          end
        end
        PZC_WAIT: begin
          if (wantPhases >= phaseCnt_r || !lowerBelow[dropIdx]) begin
            shedState_r <= PZC_IDLE;
          end else if (waitCnt_r + 24'h1 >= delayCycles) begin
            shedState_r <= PZC_DROP;
          end else begin
            waitCnt_r <= waitCnt_r + 24'h1;
          end
        end
        PZC_DROP: begin
          phaseCnt_r <= phaseCnt_r - 4'h1;
          shedState_r <= PZC_IDLE;
        end
        default: shedState_r <= PZC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phaseEn_r <= 8'hFF;
    end else begin
      for (int i = 0; i < 8; i++) begin
        phaseEn_r[i] <= (4'(i) < phaseCnt_r);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        `PZC_A_DOWNEN: rdata_r <= {7'h00, downEn_r};
        `PZC_A_PSI: rdata_r <= {6'h00, powerSavingInput};
        `PZC_A_PHASE: rdata_r <= phaseEn_r;
        `PZC_A_ZONEEN: rdata_r <= {3'h0, zoneEn_r};
        `PZC_A_ZSTRAP: rdata_r <= {2'h0, zoneStrap_r};
        `PZC_A_ZCFG: rdata_r <= {2'h0, zoneCfg_r};
        `PZC_A_LOADLINE: rdata_r <= {6'h00, loadLine_r};
        `PZC_A_TH1CFG: rdata_r <= thCfg_r[0];
        `PZC_A_TH1STR: rdata_r <= thStrap_r[0];
        `PZC_A_TH2CFG: rdata_r <= thCfg_r[1];
        `PZC_A_TH2STR: rdata_r <= thStrap_r[1];
        `PZC_A_TH3CFG: rdata_r <= thCfg_r[2];
        `PZC_A_TH3STR: rdata_r <= thStrap_r[2];
        `PZC_A_TH4CFG: rdata_r <= thCfg_r[3];
        `PZC_A_TH4STR: rdata_r <= thStrap_r[3];
        `PZC_A_HYST: rdata_r <= hyst_r;
        `PZC_A_DELAY: rdata_r <= delay_r;
        `PZC_A_LATCHA: rdata_r <= latchA_r;
        `PZC_A_LATCHB: rdata_r <= latchB_r;
        `PZC_A_OUTPUT_VOLTAGE_MONITOR: rdata_r <= outputVoltageMonitor;
        `PZC_A_POWER_STAGE_TEMP_MONITOR: rdata_r <= powerStageTempMonitor;
        default: rdata_r <= 8'h00;
      endcase
    end
  end

  assign regRdata = rdata_r;
  assign phaseEnable = phaseEn_r;
  assign downStepPhaseChangeEn = downEn_r;
  assign lowPowerZoneEnables = zoneEn_r;
  assign loadLineFraction = loadLine_r;
  assign freqCode = select_r[`PZC_B_FREQ] ? cfgFreq[4:0] : strapFreq;
  assign controlSource = {select_r[`PZC_B_FREQ], select_r[`PZC_B_SOFT], select_r[`PZC_B_ILIM],
                          select_r[`PZC_B_ZONE], select_r[`PZC_B_TH]};

  property p_down_reset;
    @(posedge clk) $rose(rst_b) |-> downEn_r;
  endproperty
  a_down_reset: assert property (p_down_reset) else $error("down-step enable not set after reset");

  property p_psi_read;
    @(posedge clk) disable iff (!rst_b) regRead && regAddr == `PZC_A_PSI |=> regRdata[7:2] == 6'h00;
  endproperty
  a_psi_read: assert property (p_psi_read) else $error("psi read upper bits not zero");

  property p_phase_read;
    @(posedge clk) disable iff (!rst_b) regRead && regAddr == `PZC_A_PHASE |=> regRdata == $past(phaseEn_r);
  endproperty
  a_phase_read: assert property (p_phase_read) else $error("phase status readback wrong");

  property p_zone_write;
    @(posedge clk) disable iff (!rst_b) regWrite && regAddr == `PZC_A_ZONEEN |=> zoneEn_r == $past(regWdata[4:0]);
  endproperty
  a_zone_write: assert property (p_zone_write) else $error("zone enable write lost");

  property p_zone_second;
    @(posedge clk) disable iff (!rst_b) select_r[`PZC_B_ZONE] && zoneCfg_r[2:0] == 3'h4 |-> zoneLevelSecond == 2'h3;
  endproperty
  a_zone_second: assert property (p_zone_second) else $error("second zone code 100 not level 3");

  property p_latch_mismatch;
    @(posedge clk) disable iff (!rst_b) latchA_r != latchB_r |=> select_r == $past(select_r);
  endproperty
  a_latch_mismatch: assert property (p_latch_mismatch) else $error("selection moved on latch mismatch");

  property p_latch_match;
    @(posedge clk) disable iff (!rst_b) latchA_r == latchB_r |=> select_r == $past(latchA_r);
  endproperty
  a_latch_match: assert property (p_latch_match) else $error("selection not taken on latch match");

  property p_freq_sel;
    @(posedge clk) disable iff (!rst_b) !select_r[`PZC_B_FREQ] |-> freqCode == strapFreq;
  endproperty
  a_freq_sel: assert property (p_freq_sel) else $error("frequency not from strap");

  property p_output_voltage_monitor;
    @(posedge clk) disable iff (!rst_b) regRead && regAddr == `PZC_A_OUTPUT_VOLTAGE_MONITOR |=> regRdata == $past(outputVoltageMonitor);
  endproperty
  a_output_voltage_monitor: assert property (p_output_voltage_monitor) else $error("voltage monitor readback wrong");

  property p_drop_after_wait;
    @(posedge clk) disable iff (!rst_b) shedState_r == PZC_DROP |-> $past(shedState_r) == PZC_WAIT;
  endproperty
  a_drop_after_wait: assert property (p_drop_after_wait) else $error("phase drop without delay");

  property p_down_write;
    @(posedge clk) disable iff (!rst_b) regWrite && regAddr == `PZC_A_DOWNEN |=> downEn_r == $past(regWdata[0]);
  endproperty
  a_down_write: assert property (p_down_write) else $error("down-step enable write lost");

  property p_load_line_write;
    @(posedge clk) disable iff (!rst_b) regWrite && regAddr == `PZC_A_LOADLINE
      |=> loadLine_r == $past(regWdata[1:0]);
  endproperty
  a_load_line_write: assert property (p_load_line_write) else $error("load-line write lost");

  property p_delay_write;
    @(posedge clk) disable iff (!rst_b) regWrite && regAddr == `PZC_A_DELAY
      |=> delay_r == $past(regWdata);
  endproperty
  a_delay_write: assert property (p_delay_write) else $error("shedding delay write lost");

  property p_power_stage_temp_monitor;
    @(posedge clk) disable iff (!rst_b) regRead && regAddr == `PZC_A_POWER_STAGE_TEMP_MONITOR
      |=> regRdata == $past(powerStageTempMonitor);
  endproperty
  a_power_stage_temp_monitor: assert property (p_power_stage_temp_monitor) else $error("temperature monitor readback wrong");

  // reserved first-field codes must not leak a level above four
  property p_zone_first;
    @(posedge clk) disable iff (!rst_b) select_r[`PZC_B_ZONE] && zoneCfg_r[5:3] > 3'h4
      |-> zoneLevelFirst == 3'h0;
  endproperty
  a_zone_first: assert property (p_zone_first) else $error("reserved first zone code not level 0");

  property p_strap_capture;
    @(posedge clk) disable iff (!rst_b) !strapDone_r
      |=> thStrap_r[0] == ($past(strapThresholdOver2V[0]) ? `PZC_TH_OFF : $past(strapThreshold[7:0])) &&
      thStrap_r[1] == ($past(strapThresholdOver2V[1]) ? `PZC_TH_OFF : $past(strapThreshold[15:8]));
  endproperty
  a_strap_capture: assert property (p_strap_capture) else $error("strapped threshold not captured");

  property p_zone_strap;
    @(posedge clk) disable iff (!rst_b) !strapDone_r |=> zoneStrap_r == $past(strapZone);
  endproperty
  a_zone_strap: assert property (p_zone_strap) else $error("strapped zone not captured");

  property p_th_off;
    @(posedge clk) disable iff (!rst_b) activeTh[0] == `PZC_TH_OFF && activeTh[1] == `PZC_TH_OFF &&
      activeTh[2] == `PZC_TH_OFF && activeTh[3] == `PZC_TH_OFF |-> wantPhases == 4'h8;
  endproperty
  a_th_off: assert property (p_th_off) else $error("disabled thresholds still shed");

  property p_rise_fast;
    @(posedge clk) disable iff (!rst_b) shedState_r == PZC_IDLE && wantPhases > phaseCnt_r
      |=> phaseCnt_r == $past(wantPhases);
  endproperty
  a_rise_fast: assert property (p_rise_fast) else $error("phase count not raised at once");

  property p_hyst_hold;
    @(posedge clk) disable iff (!rst_b) shedState_r == PZC_IDLE && !lowerBelow[dropIdx] |=> shedState_r != PZC_WAIT;
  endproperty
  a_hyst_hold: assert property (p_hyst_hold) else $error("shedding started inside hysteresis");

  // shedding must never skip a phase count on the way down
  property p_phase_step;
    @(posedge clk) disable iff (!rst_b) phaseCnt_r < $past(phaseCnt_r)
      |-> phaseCnt_r == $past(phaseCnt_r) - 4'h1;
  endproperty
  a_phase_step: assert property (p_phase_step) else $error("phase count dropped more than one");

  c_drop: cover property (@(posedge clk) disable iff (!rst_b) shedState_r == PZC_DROP);
  c_rise: cover property (@(posedge clk) disable iff (!rst_b) shedState_r == PZC_IDLE && wantPhases > phaseCnt_r);
  c_switch: cover property (@(posedge clk) disable iff (!rst_b) $rose(select_r[`PZC_B_TH]));
  c_abort: cover property (@(posedge clk) disable iff (!rst_b) shedState_r == PZC_WAIT ##1 shedState_r == PZC_IDLE);
endmodule
`default_nettype wire

// file: verif/pzc_host.sv
// register port driver standing in for the bus host
// assumes the bench calls wr and rd; signals move 1 ns after a rising edge
`timescale 1ns/100ps
`default_nettype none
module pzc_host (
  input wire logic clk,
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata,
  input wire logic [7:0] regRdata
);
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    @(posedge clk);
    #1;
    regWrite = 1'b0;
    // released data must not look like the last byte
    regWdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    regRead = 1'b1;
    regAddr = a;
    @(posedge clk);
    #1;
    regRead = 1'b0;
    regAddr = ~a;
    // read data holds, so an extra cycle costs nothing
    @(posedge clk);
    #1;
    d = regRdata;
  endtask
endmodule
`default_nettype wire

// file: verif/tb.sv
// self-checking bench for the phase/zone register bank
// assumes pzc_host drives the register port
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk = 1'b0, rst_b = 1'b0;
  logic regWrite, regRead;
  logic [7:0] regAddr, regWdata, regRdata, phaseEnable, v;
  logic [1:0] psIn = 2'h0;
  logic [7:0] cfgFreq = 8'h13, iout = 8'hC0, output_voltage_monitor = 8'h00, power_stage_temp_monitor = 8'h00;
  logic downEn;
  logic [4:0] zoneEn, freqCode, ctlSrc;
  logic [2:0] zFirst;
  logic [1:0] zSecond, llFrac;
  int miscompares = 0, totalChecks = 0, cycles = 0;
  int unsigned rng = 4753;
  logic [7:0] mdl [logic [7:0]];
  logic [7:0] msk [logic [7:0]];
  logic [7:0] rl [12] = '{8'h31, 8'h34, 8'h35, 8'h36, 8'h37, 8'h39, 8'h3A, 8'h3B, 8'h44, 8'h45, 8'h46, 8'h4B};
  pzc_host pzc_host_i (.clk(clk), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata));
  pzc_regs pzc_regs_i (.clk(clk), .rst_b(rst_b), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .powerSavingInput(psIn),
    .strapZone(6'h1A), .strapThreshold(32'h40302010), .strapThresholdOver2V(4'h2), .strapFreq(5'h0A),
    .cfgFreq(cfgFreq), .outputCurrentReadback(iout), .outputVoltageMonitor(output_voltage_monitor),
    .powerStageTempMonitor(power_stage_temp_monitor), .phaseEnable(phaseEnable), .downStepPhaseChangeEn(downEn),
    .lowPowerZoneEnables(zoneEn), .zoneLevelFirst(zFirst), .zoneLevelSecond(zSecond),
    .loadLineFraction(llFrac), .freqCode(freqCode), .controlSource(ctlSrc));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      wrapUp();
    end
  end
  function automatic logic [7:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[7:0];
  endfunction
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    totalChecks++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wrm(input logic [7:0] a, input logic [7:0] d);
    pzc_host_i.wr(a, d);
    if (msk.exists(a)) mdl[a] = d & msk[a];
  endtask
  task automatic rdc(input logic [7:0] a);
    logic [7:0] r;
    pzc_host_i.rd(a, r);
    chk("register", r, mdl.exists(a) ? mdl[a] : 8'h00);
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wrapUp();
    if (miscompares == 0 && totalChecks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    mdl = '{8'h31:8'h01, 8'h34:8'h1F, 8'h35:8'h1A, 8'h36:8'h00, 8'h39:8'h03, 8'h3A:8'hFF, 8'h3B:8'h10,
      8'h3C:8'hFF, 8'h3D:8'hFF, 8'h3E:8'hFF, 8'h3F:8'h30, 8'h40:8'hFF, 8'h41:8'h40, 8'h45:8'h14,
      8'h46:8'h00, 8'h47:8'h00};
    msk = '{8'h31:8'h01, 8'h34:8'h1F, 8'h36:8'h3F, 8'h39:8'h03, 8'h3A:8'hFF, 8'h3C:8'hFF, 8'h3E:8'hFF,
      8'h40:8'hFF, 8'h44:8'hFF, 8'h45:8'hFF, 8'h46:8'hFF, 8'h47:8'hFF};
    repeat (16) @(posedge clk);
    #1;
    rst_b = 1'b1;
    waitc(2);
    chk("down enable", {7'h0, downEn}, 8'h01);
    chk("zone enables", {3'h0, zoneEn}, 8'h1F);
    chk("load line", {6'h0, llFrac}, 8'h03);
    chk("control", {3'h0, ctlSrc}, 8'h00);
    foreach (mdl[a]) rdc(a);
    for (int i = 0; i < 40; i++) begin
      v = rl[xs() % 12];
      wrm(v, xs());
      rdc(v);
    end
    chk("down enable", {7'h0, downEn}, mdl[8'h31]);
    chk("zone enables", {3'h0, zoneEn}, mdl[8'h34]);
    chk("load line", {6'h0, llFrac}, mdl[8'h39]);
    for (int c = 0; c < 3; c++) begin
      psIn = c[1:0];
      output_voltage_monitor = xs();
      power_stage_temp_monitor = xs();
      waitc(2);
      pzc_host_i.rd(8'h32, v);
      chk("psi", v, c[7:0]);
      pzc_host_i.rd(8'h48, v);
      chk("output_voltage_monitor", v, output_voltage_monitor);
      pzc_host_i.rd(8'h49, v);
      chk("power_stage_temp_monitor", v, power_stage_temp_monitor);
    end
    // latch A alone must not switch; host writes the same byte to both
    wrm(8'h47, 8'h00);
    wrm(8'h46, 8'h22);
    cfgFreq = xs();
    wrm(8'h36, 8'h00);
    waitc(3);
    chk("control", {3'h0, ctlSrc}, 8'h00);
    chk("freq", {3'h0, freqCode}, 8'h0A);
    chk("zone first", {5'h0, zFirst}, 8'h03);
    chk("zone second", {6'h0, zSecond}, 8'h02);
    wrm(8'h47, 8'h22);
    waitc(3);
    chk("control", {3'h0, ctlSrc}, 8'h12);
    chk("freq", {3'h0, freqCode}, {3'h0, cfgFreq[4:0]});
    for (int c = 0; c < 8; c++) begin
      wrm(8'h36, {2'h0, c[2:0], c[2:0]});
      waitc(1);
      chk("zone first", {5'h0, zFirst}, c <= 4 ? c[7:0] : 8'h00);
      chk("zone second", {6'h0, zSecond}, c <= 3 ? c[7:0] : (c == 4 ? 8'h03 : 8'h00));
    end
    wrm(8'h40, 8'h40);
    wrm(8'h44, 8'h02);
    wrm(8'h45, 8'h01);
    wrm(8'h46, 8'h01);
    wrm(8'h47, 8'h01);
    for (int a = 8'h3A; a < 8'h3F; a += 2) wrm(a[7:0], 8'hFF);
    for (int a = 8'h3A; a < 8'h46; a++) rdc(a[7:0]);
    iout = 8'h3F;
    waitc(8000);
    chk("phases", phaseEnable, 8'hFF);
    iout = 8'h3D;
    waitc(2900);
    chk("phases", phaseEnable, 8'hFF);
    waitc(200);
    chk("phase count", 8'($countones(phaseEnable)), 8'h07);
    waitc(12000);
    chk("phase count", 8'($countones(phaseEnable)), 8'h04);
    pzc_host_i.rd(8'h33, v);
    chk("phase status", 8'($countones(v)), 8'h04);
    iout = 8'hC0;
    waitc(5);
    chk("phases", phaseEnable, 8'hFF);
    wrm(8'h40, 8'hFF);
    iout = 8'h00;
    waitc(4000);
    chk("phases", phaseEnable, 8'hFF);
    // strapped thresholds govern once the latches select resistors again
    wrm(8'h46, 8'h00);
    wrm(8'h47, 8'h00);
    waitc(4000);
    chk("phase count", 8'($countones(phaseEnable)), 8'h07);
    wrapUp();
  end
endmodule
`default_nettype wire
